// *** core/ctr_pkg.sv ***
// shared constants, register indices and carrier types for the ccp/timer register bank
package ctr_pkg;

  // ==========================================================
  // bus geometry
  localparam int ADDR_W = 12;
  localparam int IDX_W = 10;
  localparam int IDX_LSB = 2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [IDX_W-1:0] IDX_GIC_A = 10'h00B;
  localparam logic [IDX_W-1:0] IDX_GIC_B = 10'h08B;
  localparam logic [IDX_W-1:0] IDX_GIC_C = 10'h10B;
  localparam logic [IDX_W-1:0] IDX_GIC_D = 10'h18B;
  localparam logic [IDX_W-1:0] IDX_FLG1 = 10'h00C;
  localparam logic [IDX_W-1:0] IDX_FLG2 = 10'h00D;
  localparam logic [IDX_W-1:0] IDX_T1L = 10'h00E;
  localparam logic [IDX_W-1:0] IDX_T1H = 10'h00F;
  localparam logic [IDX_W-1:0] IDX_TIMER1_CONTROL = 10'h010;
  localparam logic [IDX_W-1:0] IDX_T2CNT = 10'h011;
  localparam logic [IDX_W-1:0] IDX_TIMER2_CONTROL = 10'h012;
  localparam logic [IDX_W-1:0] IDX_C1L = 10'h015;
  localparam logic [IDX_W-1:0] IDX_C1H = 10'h016;
  localparam logic [IDX_W-1:0] IDX_C1CON = 10'h017;
  localparam logic [IDX_W-1:0] IDX_C2L = 10'h01B;
  localparam logic [IDX_W-1:0] IDX_C2H = 10'h01C;
  localparam logic [IDX_W-1:0] IDX_C2CON = 10'h01D;
  localparam logic [IDX_W-1:0] IDX_PCDIR = 10'h087;
  localparam logic [IDX_W-1:0] IDX_EN1 = 10'h08C;
  localparam logic [IDX_W-1:0] IDX_EN2 = 10'h08D;
  localparam logic [IDX_W-1:0] IDX_T2PER = 10'h092;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h0A0;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0A1;

  // ==========================================================
  // implemented-bit masks and reset values
  localparam logic [7:0] MASK_ALL = 8'hFF;
  localparam logic [7:0] MASK_NONE = 8'h00;
  localparam logic [7:0] MASK_FLG1_LITE = 8'h4F;
  localparam logic [7:0] MASK_BIT0 = 8'h01;
  localparam logic [7:0] MASK_TIMER1_CONTROL = 8'h3F;
  localparam logic [7:0] MASK_TIMER2_CONTROL = 8'h7F;
  localparam logic [7:0] MASK_CCPCON = 8'h3F;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hFF;
  localparam int FLG1_CCP1_BIT = 2;
  localparam int FLG2_CCP2_BIT = 0;

  // ==========================================================
  // ccp control field layout and modes
  localparam int MODE_LSB = 0;
  localparam int DUTY_LSB = 4;
  localparam logic [3:0] MODE_OFF = 4'h0;
  localparam logic [3:0] MODE_CAP_FALL = 4'h4;
  localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
  localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
  localparam logic [1:0] GRP_CAPTURE = 2'h1;
  localparam logic [1:0] GRP_COMPARE = 2'h2;
  localparam logic [1:0] GRP_PWM = 2'h3;
  localparam logic [3:0] PRE_LIMIT_1 = 4'h0;
  localparam logic [3:0] PRE_LIMIT_4 = 4'h3;
  localparam logic [3:0] PRE_LIMIT_16 = 4'hF;

  // ==========================================================
  // interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IRQ_FLG1 = 0;
  localparam int IRQ_FLG2 = 1;
  localparam int IRQ_PERIOD = 2;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic low;
    logic high;
    logic ctrl;
    logic [7:0] data;
  } ctr_ccp_wr_type;

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic [7:0] ctrl;
  } ctr_ccp_regs_type;

endpackage

// *** core/ctr_ccp_unit.sv ***
// one capture/compare/pwm unit: value and control registers, prescaler, duty latch
`timescale 1ns/1ps
module ctr_ccp_unit #(
  parameter bit IMPL = 1'b1 // unit present in this variant
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic por_bor, // reset cause is power-on or brown-out
  input wire ctr_pkg::ctr_ccp_wr_type wr, // software write strobes and byte
  input wire logic t2_match, // timer2 period match pulse
  input wire logic pin_sync, // synchronised ccp pin level
  input wire logic [15:0] timer1_count, // timer1 pair for capture and compare
  output ctr_pkg::ctr_ccp_regs_type regs, // register contents
  output logic [1:0] duty_lsb, // latched pwm duty low bits
  output logic event_pulse // capture or compare event
);
  import ctr_pkg::*;

  // ==========================================================
  // state
  ctr_ccp_regs_type regs_reg, regs_next;
  logic [1:0] duty_reg, duty_next;
  logic [3:0] pre_reg, pre_next;
  logic pin_prev_reg, pin_prev_next;
  logic cmp_prev_reg, cmp_prev_next;
  logic event_reg, event_next;
  logic [3:0] mode;
  logic [3:0] pre_limit;
  logic is_cap, is_cmp, is_pwm, cap_edge, cmp_match;

  assign mode = regs_reg.ctrl[MODE_LSB +: 4];
  assign is_cap = (mode[3:2] == GRP_CAPTURE);
  assign is_cmp = (mode[3:2] == GRP_COMPARE);
  assign is_pwm = (mode[3:2] == GRP_PWM);
  assign cap_edge = (mode == MODE_CAP_FALL) ? (pin_prev_reg & ~pin_sync) : (~pin_prev_reg & pin_sync);
  assign cmp_match = ({regs_reg.high, regs_reg.low} == timer1_count);
  assign pre_limit = (mode == MODE_CAP_RISE16) ? PRE_LIMIT_16 :
                     (mode == MODE_CAP_RISE4) ? PRE_LIMIT_4 : PRE_LIMIT_1;

  // ==========================================================
  // next state
  always_comb begin
    regs_next = regs_reg;
    duty_next = duty_reg;
    pre_next = pre_reg;
    pin_prev_next = pin_sync;
    cmp_prev_next = is_cmp & cmp_match;
    event_next = 1'b0;
    if (wr.low) begin
      regs_next.low = wr.data;
    end
    if (wr.high && !is_pwm) begin
      regs_next.high = wr.data;
    end
    if (wr.ctrl) begin
      regs_next.ctrl = wr.data & MASK_CCPCON;
    end
    if (!is_cap) begin
      pre_next = PRE_LIMIT_1;
    end else if (cap_edge) begin
      if (pre_reg == pre_limit) begin
        pre_next = PRE_LIMIT_1;
        regs_next.high = timer1_count[15:8];
        regs_next.low = timer1_count[7:0];
        event_next = 1'b1;
      end else begin
        pre_next = pre_reg + 4'h1;
      end
    end
    // fire once per match, not every cycle the pair stays equal
    if (is_cmp && cmp_match && !cmp_prev_reg) begin
      event_next = 1'b1;
    end
    if (is_pwm && t2_match) begin
      regs_next.high = regs_reg.low;
      duty_next = regs_reg.ctrl[DUTY_LSB +: 2];
    end
    if (!IMPL) begin
      regs_next = '0;
      duty_next = 2'h0;
      pre_next = PRE_LIMIT_1;
      event_next = 1'b0;
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      regs_reg.ctrl <= RST_ZERO;
      duty_reg <= 2'h0;
      pre_reg <= PRE_LIMIT_1;
      pin_prev_reg <= 1'b0;
      cmp_prev_reg <= 1'b0;
      event_reg <= 1'b0;
      if (por_bor) begin
        regs_reg.low <= RST_ZERO;
        regs_reg.high <= RST_ZERO;
      end
    end else begin
      regs_reg <= regs_next;
      duty_reg <= duty_next;
      pre_reg <= pre_next;
      pin_prev_reg <= pin_prev_next;
      cmp_prev_reg <= cmp_prev_next;
      event_reg <= event_next;
    end
  end

  assign regs = regs_reg;
  assign duty_lsb = duty_reg;
  assign event_pulse = event_reg;
endmodule

// *** core/ctr_register_bank.sv ***
// ccp/timer register bank with axi4-lite slave, flag logic and interrupt output
//
// Overview of operation
// - unimplemented bits read zero, writes ignored
// - reduced variant hides port, serial, ccp2 bits
// - timer1 count bytes at 0Eh and 0Fh
// - port c direction at 87h, resets to ones
// - pwm mode: value high loaded by hardware
// - capture prescaler cleared when not capturing
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module ctr_register_bank #(
  parameter bit HAS_FULL = 1'b1 // variant has parallel port, serial port and ccp2
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic por_bor, // high: reset is power-on or brown-out
  input wire logic [ctr_pkg::ADDR_W-1:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write byte enables
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [ctr_pkg::ADDR_W-1:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic [7:0] flag_set_one, // peripheral event pulses into flags one
  input wire logic t2_period_match, // timer2 period match pulse
  input wire logic ccp1_pin, // ccp1 pin, asynchronous
  input wire logic ccp2_pin, // ccp2 pin, asynchronous
  output logic [7:0] port_c_dir, // port c direction, one means input
  output logic [7:0] timer1_ctrl, // timer1 control byte
  output logic [7:0] timer2_ctrl, // timer2 control byte
  output logic [7:0] timer2_per, // timer2 period
  output logic [9:0] ccp1_duty, // ccp1 active pwm duty
  output logic [9:0] ccp2_duty, // ccp2 active pwm duty
  output logic irq // level interrupt
);
  import ctr_pkg::*;

  localparam logic [7:0] FLG1_MASK = HAS_FULL ? MASK_ALL : MASK_FLG1_LITE;
  localparam logic [7:0] FLG2_MASK = HAS_FULL ? MASK_BIT0 : MASK_NONE;

  // ==========================================================
  // pin synchronisers
  logic [1:0] pin1_sync_reg, pin2_sync_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin1_sync_reg <= 2'h0;
      pin2_sync_reg <= 2'h0;
    end else begin
      pin1_sync_reg <= {pin1_sync_reg[0], ccp1_pin};
      pin2_sync_reg <= {pin2_sync_reg[0], ccp2_pin};
    end
  end

  // ==========================================================
  // axi4-lite channels
  logic aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [IDX_W-1:0] aw_idx_reg, aw_idx_next;
  logic [7:0] wbyte_reg, wbyte_next;
  logic wlane_reg, wlane_next;
  logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [7:0] rbyte_reg, rbyte_next;
  logic do_write, wr_hit, rd_hit;
  logic [7:0] rd_val;
  logic [IDX_W-1:0] ar_idx;

  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready = !w_held_reg && !bvalid_reg;
  assign s_axi_arready = !rvalid_reg;
  assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
  assign ar_idx = s_axi_araddr[IDX_LSB +: IDX_W];

  // ==========================================================
  // register state
  logic [7:0] gic_reg, gic_next, flg1_reg, flg1_next, flg2_reg, flg2_next;
  logic [7:0] en1_reg, en1_next, en2_reg, en2_next, t1l_reg, t1l_next, t1h_reg, t1h_next;
  logic [7:0] timer1_control_reg, timer1_control_next, t2cnt_reg, t2cnt_next, timer2_control_reg, timer2_control_next;
  logic [7:0] pcdir_reg, pcdir_next, t2per_reg, t2per_next;
  logic [IRQ_W-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [7:0] set1, set2;
  logic ccp1_event, ccp2_event;
  ctr_ccp_wr_type ccp1_wr, ccp2_wr;
  ctr_ccp_regs_type ccp1_regs, ccp2_regs;
  logic [1:0] ccp1_lsb, ccp2_lsb;

  function automatic logic wsel(input logic [IDX_W-1:0] idx);
    wsel = do_write && wlane_reg && (aw_idx_reg == idx);
  endfunction

  always_comb begin
    set1 = '0;
    set2 = '0;
    set1 = flag_set_one;
    set1[FLG1_CCP1_BIT] = flag_set_one[FLG1_CCP1_BIT] | ccp1_event;
    set1 = set1 & FLG1_MASK;
    set2[FLG2_CCP2_BIT] = ccp2_event;
    set2 = set2 & FLG2_MASK;
  end

  always_comb begin
    ccp1_wr = '0;
    ccp2_wr = '0;
    ccp1_wr.data = wbyte_reg;
    ccp2_wr.data = wbyte_reg;
    ccp1_wr.low = wsel(IDX_C1L);
    ccp1_wr.high = wsel(IDX_C1H);
    ccp1_wr.ctrl = wsel(IDX_C1CON);
    ccp2_wr.low = wsel(IDX_C2L);
    ccp2_wr.high = wsel(IDX_C2H);
    ccp2_wr.ctrl = wsel(IDX_C2CON);
  end

  // ==========================================================
  // read decode
  always_comb begin
    rd_val = RST_ZERO;
    rd_hit = 1'b1;
    case (ar_idx)
      IDX_GIC_A, IDX_GIC_B, IDX_GIC_C, IDX_GIC_D: begin
        rd_val = gic_reg;
      end
      IDX_FLG1: rd_val = flg1_reg;
      IDX_FLG2: rd_val = flg2_reg;
      IDX_EN1: rd_val = en1_reg;
      IDX_EN2: rd_val = en2_reg;
      IDX_T1L: rd_val = t1l_reg;
      IDX_T1H: rd_val = t1h_reg;
      IDX_TIMER1_CONTROL: rd_val = timer1_control_reg;
      IDX_T2CNT: rd_val = t2cnt_reg;
      IDX_TIMER2_CONTROL: rd_val = timer2_control_reg;
      IDX_T2PER: rd_val = t2per_reg;
      IDX_PCDIR: rd_val = pcdir_reg;
      IDX_C1L: rd_val = ccp1_regs.low;
      IDX_C1H: rd_val = ccp1_regs.high;
      IDX_C1CON: rd_val = ccp1_regs.ctrl;
      IDX_C2L: rd_val = ccp2_regs.low;
      IDX_C2H: rd_val = ccp2_regs.high;
      IDX_C2CON: rd_val = ccp2_regs.ctrl;
      IDX_IRQ_STAT: rd_val = {{(8-IRQ_W){1'b0}}, irq_stat_reg};
      IDX_IRQ_MASK: rd_val = {{(8-IRQ_W){1'b0}}, irq_mask_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always_comb begin
    wr_hit = 1'b1;
    case (aw_idx_reg)
      IDX_GIC_A, IDX_GIC_B, IDX_GIC_C, IDX_GIC_D, IDX_FLG1, IDX_FLG2, IDX_EN1, IDX_EN2,
      IDX_T1L, IDX_T1H, IDX_TIMER1_CONTROL, IDX_T2CNT, IDX_TIMER2_CONTROL, IDX_T2PER, IDX_PCDIR,
      IDX_C1L, IDX_C1H, IDX_C1CON, IDX_C2L, IDX_C2H, IDX_C2CON, IDX_IRQ_STAT, IDX_IRQ_MASK: begin
        wr_hit = 1'b1;
      end
      default: wr_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // next values
  always_comb begin
    aw_held_next = aw_held_reg;
    aw_idx_next = aw_idx_reg;
    w_held_next = w_held_reg;
    wbyte_next = wbyte_reg;
    wlane_next = wlane_reg;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rbyte_next = rbyte_reg;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_held_next = 1'b1;
      aw_idx_next = s_axi_awaddr[IDX_LSB +: IDX_W];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_held_next = 1'b1;
      wbyte_next = s_axi_wdata[7:0];
      wlane_next = s_axi_wstrb[0];
    end
    if (do_write) begin
      aw_held_next = 1'b0;
      w_held_next = 1'b0;
      bvalid_next = 1'b1;
      bresp_next = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_next = 1'b1;
      rbyte_next = rd_val;
      rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_next = 1'b0;
    end
  end

  // hardware sets are or-ed in last so an event beats a same-cycle clear
  always_comb begin
    gic_next = wsel(IDX_GIC_A) || wsel(IDX_GIC_B) || wsel(IDX_GIC_C) || wsel(IDX_GIC_D) ? wbyte_reg : gic_reg;
    flg1_next = (wsel(IDX_FLG1) ? (wbyte_reg & FLG1_MASK) : flg1_reg) | set1;
    flg2_next = (wsel(IDX_FLG2) ? (wbyte_reg & FLG2_MASK) : flg2_reg) | set2;
    en1_next = wsel(IDX_EN1) ? (wbyte_reg & FLG1_MASK) : en1_reg;
    en2_next = wsel(IDX_EN2) ? (wbyte_reg & FLG2_MASK) : en2_reg;
    t1l_next = wsel(IDX_T1L) ? wbyte_reg : t1l_reg;
    t1h_next = wsel(IDX_T1H) ? wbyte_reg : t1h_reg;
    timer1_control_next = wsel(IDX_TIMER1_CONTROL) ? (wbyte_reg & MASK_TIMER1_CONTROL) : timer1_control_reg;
    t2cnt_next = wsel(IDX_T2CNT) ? wbyte_reg : t2cnt_reg;
    timer2_control_next = wsel(IDX_TIMER2_CONTROL) ? (wbyte_reg & MASK_TIMER2_CONTROL) : timer2_control_reg;
    t2per_next = wsel(IDX_T2PER) ? wbyte_reg : t2per_reg;
    pcdir_next = wsel(IDX_PCDIR) ? wbyte_reg : pcdir_reg;
    irq_mask_next = wsel(IDX_IRQ_MASK) ? wbyte_reg[IRQ_W-1:0] : irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (wsel(IDX_IRQ_STAT)) begin
      irq_stat_next = irq_stat_reg & ~wbyte_reg[IRQ_W-1:0];
    end
    irq_stat_next[IRQ_FLG1] = irq_stat_next[IRQ_FLG1] | (|set1);
    irq_stat_next[IRQ_FLG2] = irq_stat_next[IRQ_FLG2] | (|set2);
    irq_stat_next[IRQ_PERIOD] = irq_stat_next[IRQ_PERIOD] | t2_period_match;
  end

  // ==========================================================
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_idx_reg <= '0;
      w_held_reg <= 1'b0;
      wbyte_reg <= RST_ZERO;
      wlane_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rbyte_reg <= RST_ZERO;
      flg1_reg <= RST_ZERO;
      flg2_reg <= RST_ZERO;
      en1_reg <= RST_ZERO;
      en2_reg <= RST_ZERO;
      t2cnt_reg <= RST_ZERO;
      timer2_control_reg <= RST_ZERO;
      t2per_reg <= RST_ONES;
      pcdir_reg <= RST_ONES;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      if (por_bor) begin
        gic_reg <= RST_ZERO;
        t1l_reg <= RST_ZERO;
        t1h_reg <= RST_ZERO;
        timer1_control_reg <= RST_ZERO;
      end else begin
        gic_reg <= gic_reg & MASK_BIT0;
      end
    end else begin
      aw_held_reg <= aw_held_next;
      aw_idx_reg <= aw_idx_next;
      w_held_reg <= w_held_next;
      wbyte_reg <= wbyte_next;
      wlane_reg <= wlane_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rbyte_reg <= rbyte_next;
      gic_reg <= gic_next;
      flg1_reg <= flg1_next;
      flg2_reg <= flg2_next;
      en1_reg <= en1_next;
      en2_reg <= en2_next;
      t1l_reg <= t1l_next;
      t1h_reg <= t1h_next;
      timer1_control_reg <= timer1_control_next;
      t2cnt_reg <= t2cnt_next;
      timer2_control_reg <= timer2_control_next;
      t2per_reg <= t2per_next;
      pcdir_reg <= pcdir_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ==========================================================
  // ccp units; the second is stripped in the reduced variant
  ctr_ccp_unit #(.IMPL(1'b1)) u_ccp1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .por_bor(por_bor),
    .wr(ccp1_wr),
    .t2_match(t2_period_match),
    .pin_sync(pin1_sync_reg[1]),
    .timer1_count({t1h_reg, t1l_reg}),
    .regs(ccp1_regs),
    .duty_lsb(ccp1_lsb),
    .event_pulse(ccp1_event)
  );

  ctr_ccp_unit #(.IMPL(HAS_FULL)) u_ccp2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .por_bor(por_bor),
    .wr(ccp2_wr),
    .t2_match(t2_period_match),
    .pin_sync(pin2_sync_reg[1]),
    .timer1_count({t1h_reg, t1l_reg}),
    .regs(ccp2_regs),
    .duty_lsb(ccp2_lsb),
    .event_pulse(ccp2_event)
  );

  // ==========================================================
  // outputs
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = {24'h000000, rbyte_reg};
  assign port_c_dir = pcdir_reg;
  assign timer1_ctrl = timer1_control_reg;
  assign timer2_ctrl = timer2_control_reg;
  assign timer2_per = t2per_reg;
  assign ccp1_duty = {ccp1_regs.high, ccp1_lsb};
  assign ccp2_duty = {ccp2_regs.high, ccp2_lsb};
  assign irq = |(irq_stat_reg & irq_mask_reg);
endmodule

// *** tb/ctr_register_bank_properties.sv ***
// concurrent checks on the ports of the ccp/timer register bank
`timescale 1ns/1ps
module ctr_register_bank_properties (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset, active low
  input wire logic t2_period_match, // period match pulse
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic s_axi_rvalid, // read data valid
  input wire logic [7:0] port_c_dir, // port c direction
  input wire logic [7:0] timer1_ctrl, // timer1 control
  input wire logic [7:0] timer2_ctrl, // timer2 control
  input wire logic [7:0] timer2_per, // timer2 period
  input wire logic [9:0] ccp1_duty, // ccp1 duty
  input wire logic [9:0] ccp2_duty, // ccp2 duty
  input wire logic irq // level interrupt
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // reset values, seen at the first edge after release
  a_dir_after_reset: assert property ($rose(aresetn) |-> port_c_dir == 8'hFF)
    else $error("direction not all ones after reset");
  a_per_after_reset: assert property ($rose(aresetn) |-> timer2_per == 8'hFF && timer2_ctrl == 8'h00)
    else $error("timer2 registers wrong after reset");
  a_irq_after_reset: assert property ($rose(aresetn) |-> !irq)
    else $error("interrupt high after reset");
  // ==========================================================
  // unimplemented bits
  a_t1_unimpl: assert property (timer1_ctrl[7:6] == 2'h0)
    else $error("timer1 control top bits set");
  a_t2_unimpl: assert property (!timer2_ctrl[7])
    else $error("timer2 control bit7 set");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  // ==========================================================
  // duty low bits move only after a period match
  a_duty1_latch: assert property ($changed(ccp1_duty[1:0]) |-> $past(t2_period_match))
    else $error("ccp1 duty bits moved without period match");
  a_duty2_latch: assert property ($changed(ccp2_duty[1:0]) |-> $past(t2_period_match))
    else $error("ccp2 duty bits moved without period match");
endmodule

// *** tb/tb_ctr_register_bank.sv ***
// self-checking bench for the ccp/timer register bank
`timescale 1ns/1ps
module tb_ctr_register_bank;
  import ctr_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic por_bor = 1'b1;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, t2m = 1'b0, p1 = 1'b0;
  logic [7:0] fset = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rv;
  logic [7:0] pdir, t1c, t2c, t2p, hv, f;
  logic [9:0] d1, d2;
  logic [31:0] seed = 32'h7F2A0E13;
  logic [7:0] kept [logic [9:0]];
  int bad_count = 0;
  int tests_run = 0;

  always #50 aclk = ~aclk;

  ctr_register_bank dut_u (.aclk(aclk), .aresetn(aresetn), .por_bor(por_bor),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .flag_set_one(fset), .t2_period_match(t2m), .ccp1_pin(p1), .ccp2_pin(1'b0),
    .port_c_dir(pdir), .timer1_ctrl(t1c), .timer2_ctrl(t2c), .timer2_per(t2p), .ccp1_duty(d1),
    .ccp2_duty(d2), .irq(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // ==========================================================
  // bus cycles: both channels offered together, response awaited
  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 50);
    resp = bresp;
    bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, bvalid});
  endtask

  task automatic rd(input logic [9:0] idx);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 50);
    rv = rdata;
    resp = rresp;
    rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, rvalid});
  endtask

  task automatic rdchk(input string nm, input logic [9:0] idx, input logic [7:0] e, input logic [1:0] er);
    rd(idx);
    chk(nm, {24'h000000, e}, rv);
    chk("rresp", {30'h0, er}, {30'h0, resp});
  endtask

  task automatic do_reset(input logic pb);
    @(posedge aclk);
    aresetn <= 1'b0;
    por_bor <= pb;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic pulse(input logic [7:0] fl, input logic t);
    @(posedge aclk);
    fset <= fl;
    t2m <= t;
    @(posedge aclk);
    fset <= 8'h00;
    t2m <= 1'b0;
  endtask

  // k rising edges on the ccp1 pin, spaced past the synchroniser delay
  task automatic edges(input int k);
    repeat (2 * k) begin
      repeat (4) @(posedge aclk);
      p1 <= ~p1;
    end
  endtask

  task automatic end_sim;
    $display("tests %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [9:0] ix [9];
    logic [7:0] mk [9];
    ix = '{IDX_TIMER1_CONTROL, IDX_TIMER2_CONTROL, IDX_C1CON, IDX_C2CON, IDX_T1L, IDX_T1H, IDX_PCDIR, IDX_T2PER, IDX_C1L};
    mk = '{MASK_TIMER1_CONTROL, MASK_TIMER2_CONTROL, MASK_CCPCON, MASK_CCPCON, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    do_reset(1'b1);
    chk("port_c_dir", 32'hFF, {24'h0, pdir});
    rdchk("dir", IDX_PCDIR, 8'hFF, RESP_OKAY);
    rdchk("per", IDX_T2PER, 8'hFF, RESP_OKAY);
    rdchk("flags1", IDX_FLG1, 8'h00, RESP_OKAY);
    rdchk("timer2_control", IDX_TIMER2_CONTROL, 8'h00, RESP_OKAY);
    rdchk("gic", IDX_GIC_C, 8'h00, RESP_OKAY);
    $display("test power-on values done");
    for (int i = 0; i < 9; i++) begin
      repeat (8) seed = lfsr(seed);
      kept[ix[i]] = seed[7:0] & mk[i];
      wr(ix[i], seed[7:0]);
      rdchk("masked", ix[i], kept[ix[i]], RESP_OKAY);
    end
    chk("t1 ctrl port", {24'h0, kept[IDX_TIMER1_CONTROL]}, {24'h0, t1c});
    chk("t2 ctrl port", {24'h0, kept[IDX_TIMER2_CONTROL]}, {24'h0, t2c});
    chk("t2 per port", {24'h0, kept[IDX_T2PER]}, {24'h0, t2p});
    wr(IDX_C2CON, 8'h00);
    wr(10'h013, 8'h5A);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    rdchk("unmapped", 10'h013, 8'h00, RESP_SLVERR);
    $display("test masks done");
    // warm reset keeps timer1 and ccp values
    do_reset(1'b0);
    rdchk("t1 low", IDX_T1L, kept[IDX_T1L], RESP_OKAY);
    rdchk("t1 high", IDX_T1H, kept[IDX_T1H], RESP_OKAY);
    rdchk("t1 ctrl", IDX_TIMER1_CONTROL, kept[IDX_TIMER1_CONTROL], RESP_OKAY);
    rdchk("c1 low", IDX_C1L, kept[IDX_C1L], RESP_OKAY);
    rdchk("dir warm", IDX_PCDIR, 8'hFF, RESP_OKAY);
    rdchk("per warm", IDX_T2PER, 8'hFF, RESP_OKAY);
    rdchk("c1 ctrl", IDX_C1CON, 8'h00, RESP_OKAY);
    $display("test warm reset done");
    rd(IDX_C1H);
    hv = rv[7:0];
    wr(IDX_C1CON, 8'h2C);
    wr(IDX_C1H, ~hv);
    rdchk("high held", IDX_C1H, hv, RESP_OKAY);
    pulse(8'h00, 1'b1);
    rdchk("high load", IDX_C1H, kept[IDX_C1L], RESP_OKAY);
    chk("duty", {22'h0, kept[IDX_C1L], 2'b10}, {22'h0, d1});
    rdchk("period status", IDX_IRQ_STAT, 8'h04, RESP_OKAY);
    $display("test pwm latch done");
    wr(IDX_IRQ_MASK, 8'h01);
    chk("irq masked", 32'h0, {31'h0, irq});
    f = seed[15:8] | 8'h01;
    pulse(f, 1'b0);
    rdchk("flags set", IDX_FLG1, f, RESP_OKAY);
    chk("irq raised", 32'h1, {31'h0, irq});
    wr(IDX_FLG1, 8'h00);
    wr(IDX_IRQ_STAT, 8'h07);
    rdchk("status clear", IDX_IRQ_STAT, 8'h00, RESP_OKAY);
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test interrupt done");
    // leaving capture mode must drop the partial prescaler count
    wr(IDX_C1CON, 8'h06);
    edges(2);
    wr(IDX_C1CON, 8'h00);
    wr(IDX_C1CON, 8'h06);
    edges(3);
    rdchk("no capture", IDX_FLG1, 8'h00, RESP_OKAY);
    edges(1);
    rdchk("capture", IDX_FLG1, 8'h04, RESP_OKAY);
    $display("test capture prescaler done");
    end_sim;
  end

  // hang guard, well past the few hundred cycles the tests need
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    end_sim;
  end
endmodule

bind ctr_register_bank ctr_register_bank_properties chk_u (.aclk(aclk), .aresetn(aresetn),
  .t2_period_match(t2_period_match), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .port_c_dir(port_c_dir), .timer1_ctrl(timer1_ctrl), .timer2_ctrl(timer2_ctrl), .timer2_per(timer2_per),
  .ccp1_duty(ccp1_duty), .ccp2_duty(ccp2_duty), .irq(irq));
